/* design/adc_port_cfg.svh */
// Constants for the converter output and serial configuration port.
// Assumes inclusion by the two design files by bare name.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ==========================================================
// Timing
`define REF_CLK_HZ 10000000
`define REF_PERIOD_NS (1000000000 / `REF_CLK_HZ)
`define STBY_PERIOD_NS 1000
`define STBY_CYC (`STBY_PERIOD_NS / `REF_PERIOD_NS)
`define LATENCY_SAMPLES 7
`define STRAP_SETTLE 2'h3

// ==========================================================
// Serial framing
`define INSTR_LAST 4'hF
`define BYTE_LAST 4'h7
`define INSTR_RW_BIT 15
`define INSTR_LEN_HI 14
`define INSTR_LEN_LO 13

// ==========================================================
// Register offsets
`define ADDR_PORT_CFG 8'h00
`define ADDR_CHIP_ID 8'h01
`define ADDR_CLOCK 8'h09
`define ADDR_OUT_MODE 8'h14
`define ADDR_OUT_DRIVE 8'h15

// ==========================================================
// Reset values
`define RST_PORT_CFG 8'h18
`define RST_CLOCK 8'h01
`define RST_OUT_MODE 8'h00
`define RST_OUT_DRIVE 8'h00
`define RST_OTHER 8'h00

// ==========================================================
// Field positions
`define BIT_LSB_FIRST 6
`define BIT_DCS 0
`define BIT_TWOS 0
`define BIT_DDR 3
`define BIT_REDUCED 0

`endif

/* design/adc_port_pkg.sv */
// Types shared by the output port and its configuration memory.
// Assumes the constants header is on the include path.
package adc_port_pkg;

  // ========================================================
  // Types
  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_HIGH = 4'h2,
    PH_ODD  = 4'h4,
    PH_LOW  = 4'h8
  } dco_phase_e;

  typedef enum logic [2:0] {
    SER_INSTR = 3'h1,
    SER_DATA  = 3'h2,
    SER_DONE  = 3'h4
  } ser_state_e;

endpackage

/* design/cfg_regfile.sv */
// Byte-wide configuration memory on the serial clock.
// Assumes an asynchronous active-low master reset and one write port.
`timescale 1ns/1ps
`include "adc_port_cfg.svh"

module cfg_regfile #(
  parameter int ADDR_W = 8,
  // Identification value is arbitrary
  parameter logic [7:0] CHIP_ID = 8'h5A
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_waddr,
  input wire adc_port_pkg::byte_t i_wdata,
  input wire logic [ADDR_W-1:0] i_raddr,
  output adc_port_pkg::byte_t o_rdata,
  output adc_port_pkg::byte_t o_port_cfg,
  output adc_port_pkg::byte_t o_clock_cfg,
  output adc_port_pkg::byte_t o_out_mode,
  output adc_port_pkg::byte_t o_out_drive
);
  import adc_port_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  byte_t mem [DEPTH];

  function automatic byte_t def_val(input int a);
    case (a)
      int'(`ADDR_PORT_CFG): def_val = `RST_PORT_CFG;
      int'(`ADDR_CHIP_ID): def_val = CHIP_ID;
      int'(`ADDR_CLOCK): def_val = `RST_CLOCK;
      int'(`ADDR_OUT_MODE): def_val = `RST_OUT_MODE;
      int'(`ADDR_OUT_DRIVE): def_val = `RST_OUT_DRIVE;
      default: def_val = `RST_OTHER;
    endcase
  endfunction

  // ========================================================
  // Storage, one byte per address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= def_val(i);
      end
    end else if (i_we && i_waddr != ADDR_W'(`ADDR_CHIP_ID)) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data registered so the shifter sees a settled byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

  assign o_port_cfg = mem[ADDR_W'(`ADDR_PORT_CFG)];
  assign o_clock_cfg = mem[ADDR_W'(`ADDR_CLOCK)];
  assign o_out_mode = mem[ADDR_W'(`ADDR_OUT_MODE)];
  assign o_out_drive = mem[ADDR_W'(`ADDR_OUT_DRIVE)];

endmodule

/* design/adc_output_port.sv */
// Output formatter, capture clock and serial configuration port.
// Assumes conversions arrive as one-cycle strobes on the reference
// clock, at least four cycles apart; the serial clock is the host's.
`timescale 1ns/1ps
`include "adc_port_cfg.svh"

module adc_output_port #(
  parameter int DATA_W = 12,
  parameter int LATENCY = `LATENCY_SAMPLES,
  parameter int STBY_CYC = `STBY_CYC
) (
  // Reference clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_MASTER_RESET_N,
  // Converter core results
  input wire logic I_CONV_VALID,
  input wire logic [DATA_W-1:0] I_CONV_DATA,
  input wire logic I_CONV_OVER_RANGE,
  // Serial configuration pins
  input wire logic I_SERIAL_SHIFT_CLOCK_FORMAT_STRAP,
  input wire logic I_SERIAL_CHIP_SELECT_N,
  input wire logic I_BIDIR_SERIAL_DATA_STABILIZER_STRAP,
  output logic O_BIDIR_SERIAL_DATA_STABILIZER_STRAP,
  output logic O_BIDIR_SERIAL_DATA_STABILIZER_STRAP_OE,
  // Output link
  output logic [DATA_W-1:0] O_DATA,
  output logic O_OUT_OF_RANGE,
  output logic O_DATA_CAPTURE_CLOCK_OUT,
  // Status and settings
  output logic O_DDR_MODE,
  output logic O_TWOS_COMPLEMENT,
  output logic O_LVDS_REDUCED_SWING,
  output logic O_DUTY_CYCLE_STABILIZER,
  output logic O_STANDBY
);
  import adc_port_pkg::*;

  localparam int HALF_W = DATA_W / 2;
  localparam int SYNC_W = 7;

  function automatic byte_t bit_rev8(input byte_t v);
    for (int i = 0; i < 8; i++) begin
      bit_rev8[i] = v[7-i];
    end
  endfunction

  function automatic logic [15:0] bit_rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      bit_rev16[i] = v[15-i];
    end
  endfunction

  // ========================================================
  // Serial port, on the host's shift clock
  wire logic sclk = I_SERIAL_SHIFT_CLOCK_FORMAT_STRAP;
  wire logic sdi = I_BIDIR_SERIAL_DATA_STABILIZER_STRAP;
  // Chip select high ends the frame even though the clock has stopped
  wire logic frame_rst = I_SERIAL_CHIP_SELECT_N | ~I_MASTER_RESET_N;

  ser_state_e st_r;
  logic [3:0] cnt_r;
  logic [14:0] sr_r;
  logic rw_r;
  logic [1:0] len_r;
  logic [1:0] bytes_r;
  byte_t addr_r;
  byte_t raddr;
  byte_t rdata;
  byte_t port_cfg;
  byte_t clock_cfg;
  byte_t out_mode;
  byte_t out_drive;
  logic lsb_first;
  logic [15:0] instr;
  byte_t wdata;
  logic we;

  assign lsb_first = port_cfg[`BIT_LSB_FIRST];
  assign instr = lsb_first ? bit_rev16({sr_r, sdi}) : {sr_r, sdi};
  assign wdata = lsb_first ? bit_rev8({sr_r[6:0], sdi})
                           : {sr_r[6:0], sdi};
  assign we = st_r == SER_DATA && !rw_r && cnt_r == `BYTE_LAST;

  always_comb begin
    raddr = addr_r;
    if (st_r == SER_INSTR && cnt_r == `INSTR_LAST) begin
      raddr = instr[7:0];
    end else if (st_r == SER_DATA && cnt_r == `BYTE_LAST) begin
      raddr = addr_r + 8'h01;
    end
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      st_r <= SER_INSTR;
      cnt_r <= 4'h0;
      sr_r <= 15'h0000;
    end else begin
      sr_r <= {sr_r[13:0], sdi};
      cnt_r <= cnt_r + 4'h1;
      unique case (st_r)
        SER_INSTR: begin
          if (cnt_r == `INSTR_LAST) begin
            st_r <= SER_DATA;
            cnt_r <= 4'h0;
          end
        end
        SER_DATA: begin
          if (cnt_r == `BYTE_LAST) begin
            cnt_r <= 4'h0;
            if (bytes_r == len_r) begin
              st_r <= SER_DONE;
            end
          end
        end
        SER_DONE: begin
          cnt_r <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rw_r <= 1'b0;
      len_r <= 2'h0;
      bytes_r <= 2'h0;
      addr_r <= 8'h00;
    end else if (st_r == SER_INSTR && cnt_r == `INSTR_LAST) begin
      rw_r <= instr[`INSTR_RW_BIT];
      len_r <= instr[`INSTR_LEN_HI:`INSTR_LEN_LO];
      bytes_r <= 2'h0;
      addr_r <= instr[7:0];
    end else if (st_r == SER_DATA && cnt_r == `BYTE_LAST) begin
      bytes_r <= bytes_r + 2'h1;
      addr_r <= raddr;
    end
  end

  // Drive on the falling edge so the host samples a settled bit
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      O_BIDIR_SERIAL_DATA_STABILIZER_STRAP <= 1'b0;
      O_BIDIR_SERIAL_DATA_STABILIZER_STRAP_OE <= 1'b0;
    end else begin
      O_BIDIR_SERIAL_DATA_STABILIZER_STRAP <=
        lsb_first ? rdata[cnt_r[2:0]] : rdata[3'h7 - cnt_r[2:0]];
      O_BIDIR_SERIAL_DATA_STABILIZER_STRAP_OE <=
        st_r == SER_DATA && rw_r;
    end
  end

  cfg_regfile #(
    .ADDR_W(8)
  ) u_regs (
    .i_clk(sclk),
    .i_rst_n(I_MASTER_RESET_N),
    .i_we(we),
    .i_waddr(addr_r),
    .i_wdata(wdata),
    .i_raddr(raddr),
    .o_rdata(rdata),
    .o_port_cfg(port_cfg),
    .o_clock_cfg(clock_cfg),
    .o_out_mode(out_mode),
    .o_out_drive(out_drive)
  );

  // ========================================================
  // Crossing into the reference domain
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] stable_r;

  assign sync_in = {I_SERIAL_CHIP_SELECT_N, sdi, sclk,
                    clock_cfg[`BIT_DCS], out_mode[`BIT_DDR],
                    out_mode[`BIT_TWOS], out_drive[`BIT_REDUCED]};

  // Config bits are quasi-static, so per-bit agreement is enough
  generate
    for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge I_REF_CLK) begin
        s1_r[g] <= sync_in[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (I_SRST) begin
          stable_r[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          stable_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  // ========================================================
  // Strap capture after reset release
  logic [1:0] settle_r;
  logic strap_mode_r;
  logic strap_dcs_r;
  logic strap_twos_r;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      settle_r <= 2'h0;
      strap_mode_r <= 1'b0;
      strap_dcs_r <= 1'b0;
      strap_twos_r <= 1'b0;
    end else if (settle_r != `STRAP_SETTLE) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r + 2'h1 == `STRAP_SETTLE) begin
        strap_mode_r <= ~stable_r[6];
        strap_dcs_r <= stable_r[5];
        strap_twos_r <= stable_r[4];
      end
    end
  end

  logic twos_eff;
  logic ddr_eff;

  assign twos_eff = strap_mode_r ? strap_twos_r : stable_r[1];
  assign ddr_eff = strap_mode_r ? 1'b0 : stable_r[2];

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_DUTY_CYCLE_STABILIZER <= 1'b1;
      O_LVDS_REDUCED_SWING <= 1'b0;
    end else begin
      O_DUTY_CYCLE_STABILIZER <=
        strap_mode_r ? strap_dcs_r : stable_r[3];
      O_LVDS_REDUCED_SWING <= !strap_mode_r && stable_r[0];
    end
  end

  // ========================================================
  // Conversion pipeline and standby
  logic [DATA_W:0] pipe_r [LATENCY];
  logic [$clog2(STBY_CYC+2)-1:0] gap_r;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_r[i] <= '0;
      end
    end else if (I_CONV_VALID) begin
      pipe_r[0] <= {I_CONV_OVER_RANGE, I_CONV_DATA};
      for (int i = 1; i < LATENCY; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // Rate is judged by the gap between conversion strobes
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      gap_r <= '0;
      O_STANDBY <= 1'b0;
    end else if (I_CONV_VALID) begin
      gap_r <= '0;
      O_STANDBY <= 1'b0;
    end else if (gap_r > ($bits(gap_r))'(STBY_CYC)) begin
      O_STANDBY <= 1'b1;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end

  // ========================================================
  // Output launch and capture clock
  dco_phase_e ph_r;
  logic [DATA_W-1:0] word_r;
  logic [DATA_W-1:0] fmt_word;

  assign fmt_word = pipe_r[LATENCY-1][DATA_W-1:0]
                    ^ {twos_eff, {(DATA_W-1){1'b0}}};

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      ph_r <= PH_IDLE;
      word_r <= '0;
      O_DATA <= '0;
      O_OUT_OF_RANGE <= 1'b0;
      O_DATA_CAPTURE_CLOCK_OUT <= 1'b0;
      O_DDR_MODE <= 1'b0;
      O_TWOS_COMPLEMENT <= 1'b0;
    end else if (I_CONV_VALID) begin
      ph_r <= PH_HIGH;
      word_r <= fmt_word;
      O_DDR_MODE <= ddr_eff;
      O_TWOS_COMPLEMENT <= twos_eff;
      O_OUT_OF_RANGE <= pipe_r[LATENCY-1][DATA_W];
      O_DATA_CAPTURE_CLOCK_OUT <= 1'b0;
      for (int i = 0; i < HALF_W; i++) begin
        if (ddr_eff) begin
          O_DATA[i] <= fmt_word[2*i];
          O_DATA[HALF_W+i] <= 1'b0;
        end else begin
          O_DATA[i] <= fmt_word[i];
          O_DATA[HALF_W+i] <= fmt_word[HALF_W+i];
        end
      end
    end else begin
      unique case (ph_r)
        PH_IDLE: ph_r <= PH_IDLE;
        PH_HIGH: begin
          O_DATA_CAPTURE_CLOCK_OUT <= 1'b1;
          ph_r <= PH_ODD;
        end
        PH_ODD: begin
          if (O_DDR_MODE) begin
            for (int i = 0; i < HALF_W; i++) begin
              O_DATA[i] <= word_r[2*i+1];
            end
          end
          ph_r <= PH_LOW;
        end
        PH_LOW: begin
          O_DATA_CAPTURE_CLOCK_OUT <= 1'b0;
          ph_r <= PH_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);

  sequence lone_conv;
    I_CONV_VALID ##1 !I_CONV_VALID [*3];
  endsequence

  sequence dco_pulse;
    !O_DATA_CAPTURE_CLOCK_OUT ##1 O_DATA_CAPTURE_CLOCK_OUT
      ##1 O_DATA_CAPTURE_CLOCK_OUT;
  endsequence

  dco_rate_a: assert property (
    I_CONV_VALID |=> dco_pulse ##1 !O_DATA_CAPTURE_CLOCK_OUT)
    else $error("capture clock pulse malformed");

  dco_shape_a: assert property (
    lone_conv |->
      O_DATA_CAPTURE_CLOCK_OUT && $past(O_DATA_CAPTURE_CLOCK_OUT))
    else $error("capture clock not high after conversion");

  or_with_data_a: assert property (
    $changed(O_OUT_OF_RANGE) |-> $past(I_CONV_VALID))
    else $error("range flag moved without a data launch");

  data_launch_a: assert property (
    $changed(O_DATA) |-> $past(I_CONV_VALID) || $past(ph_r == PH_ODD))
    else $error("data changed outside a launch slot");

  ddr_upper_a: assert property (
    O_DDR_MODE |-> O_DATA[DATA_W-1:HALF_W] == '0)
    else $error("upper pairs active in double rate");

  format_msb_a: assert property (
    I_CONV_VALID && !ddr_eff |=>
      O_DATA[DATA_W-1] == ($past(pipe_r[LATENCY-1][DATA_W-1])
                           ^ $past(twos_eff)))
    else $error("output coding wrong");

  standby_exit_a: assert property (
    I_CONV_VALID |=> !O_STANDBY ##1 (!O_STANDBY || !$past(I_CONV_VALID, 2)))
    else $error("standby held despite conversions");

  strap_apply_a: assert property (
    strap_mode_r && $stable(strap_mode_r) |=>
      O_DUTY_CYCLE_STABILIZER == strap_dcs_r && !O_LVDS_REDUCED_SWING)
    else $error("strap setting not applied");

  instr_end_a: assert property (
    @(posedge sclk) disable iff (frame_rst)
    st_r == SER_INSTR && cnt_r == `INSTR_LAST |=> st_r == SER_DATA)
    else $error("instruction phase length wrong");

  read_drive_a: assert property (
    @(negedge sclk) disable iff (frame_rst)
    O_BIDIR_SERIAL_DATA_STABILIZER_STRAP_OE |-> rw_r)
    else $error("data pin driven outside a read");

endmodule

/* sim/cfg_host_model.sv */
// Serial configuration host for the three-wire port.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module cfg_host_model (
  // Serial pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_sdio
);
  // ==========================================================
  // Idle state
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdo = 1'b0;
    o_sdo_oe = 1'b0;
  end

  // ==========================================================
  // Static levels, for pin straps or parking
  task automatic strap(input logic cs_n, input logic oe, input logic d,
      input logic c);
    o_cs_n = cs_n;
    o_sdo_oe = oe;
    o_sdo = d;
    o_sclk = c;
  endtask

  // Data changes while the clock is low; sampled at the rise
  task automatic tick(input logic drv, input logic d, output logic q);
    o_sdo_oe = drv;
    o_sdo = d;
    #3 o_sclk = 1'b1;
    q = i_sdio;
    #3 o_sclk = 1'b0;
  endtask

  // ==========================================================
  // One frame; sel low clocks it with chip select left high
  task automatic frame(input logic rd, input logic [1:0] len,
      input logic [7:0] addr, input logic [31:0] wd, input logic lsb,
      input logic sel, output logic [31:0] rdat);
    logic [15:0] ins;
    logic q;
    int b;
    ins = {rd, len, 5'h00, addr};
    rdat = 32'h0;
    o_cs_n = ~sel;
    #5;
    for (int i = 0; i < 16; i++) begin
      tick(1'b1, ins[lsb ? i : 15 - i], q);
    end
    for (int k = 0; k <= len; k++) begin
      for (int i = 0; i < 8; i++) begin
        b = 31 - 8 * k - (lsb ? 7 - i : i);
        tick(~rd, wd[b], q);
        rdat[b] = q;
      end
    end
    #3 o_cs_n = 1'b1;
    o_sdo_oe = 1'b0;
  endtask
endmodule

/* sim/test_adc_output_and_serial_config_port.sv */
// Self-checking bench for the converter output and serial port.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module test_adc_output_and_serial_config_port;
  import adc_port_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk, srst, mrst_n, conv_valid, conv_or;
  logic [11:0] conv_data, o_data, dw;
  logic sclk, cs_n, h_sdo, h_oe, d_sdo, d_oe, sdio;
  logic o_or, data_capture_clock_out, ddr, twos, reduced, duty_cycle_stabilizer, stby;
  logic ddr_m, twos_m, lsb_m;
  logic [12:0] q[$];
  logic [12:0] w;
  logic [5:0] even;
  logic [31:0] rd;
  logic [7:0] ra[5] = '{8'h00, 8'h01, 8'h09, 8'h14, 8'h15};
  logic [7:0] rv[5] = '{8'h18, 8'h5A, 8'h01, 8'h00, 8'h00};
  int num_errors, n_tests, seed;

  // Shared data wire with pull-up; two drivers show as unknown
  assign sdio = (d_oe && h_oe) ? 1'bx :
    d_oe ? d_sdo : h_oe ? h_sdo : 1'b1;

  adc_output_port dut_u (
    .I_REF_CLK(ref_clk), .I_SRST(srst), .I_MASTER_RESET_N(mrst_n),
    .I_CONV_VALID(conv_valid), .I_CONV_DATA(conv_data),
    .I_CONV_OVER_RANGE(conv_or),
    .I_SERIAL_SHIFT_CLOCK_FORMAT_STRAP(sclk),
    .I_SERIAL_CHIP_SELECT_N(cs_n),
    .I_BIDIR_SERIAL_DATA_STABILIZER_STRAP(sdio),
    .O_BIDIR_SERIAL_DATA_STABILIZER_STRAP(d_sdo),
    .O_BIDIR_SERIAL_DATA_STABILIZER_STRAP_OE(d_oe),
    .O_DATA(o_data), .O_OUT_OF_RANGE(o_or),
    .O_DATA_CAPTURE_CLOCK_OUT(data_capture_clock_out), .O_DDR_MODE(ddr),
    .O_TWOS_COMPLEMENT(twos), .O_LVDS_REDUCED_SWING(reduced),
    .O_DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .O_STANDBY(stby));

  cfg_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdo(h_sdo),
    .o_sdo_oe(h_oe), .i_sdio(sdio));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    close_out();
  end

  // ==========================================================
  // Receiver side: SDR on capture clock rise, DDR on both edges
  always @(posedge data_capture_clock_out) begin
    if (q.size() > 0) begin
      if (ddr_m) begin
        even = o_data[5:0];
      end else begin
        chk({o_or, o_data}, q.pop_front());
        chk({ddr, twos}, {1'b0, twos_m});
      end
    end
  end

  always @(negedge data_capture_clock_out) begin
    if (ddr_m && q.size() > 0) begin
      w = q.pop_front();
      for (int i = 0; i < 6; i++) begin
        dw[2 * i] = even[i];
        dw[2 * i + 1] = o_data[i];
      end
      chk({o_or, o_data[11:6]}, {w[12], 6'h00});
      chk(dw, w[11:0]);
      chk({ddr, twos}, {1'b1, twos_m});
    end
  end

  // ==========================================================
  // Drivers
  task automatic reset_dut(input logic cs, input logic d, input logic c);
    @(negedge ref_clk);
    host_u.strap(cs, 1'b1, d, c);
    srst = 1'b1;
    repeat (20) @(negedge ref_clk);
    mrst_n = 1'b1;
    srst = 1'b0;
    repeat (8) @(negedge ref_clk);
    if (cs) host_u.strap(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // Strobes four cycles apart; the first seven flush the pipeline
  task automatic stream(input int n, input logic tw, input logic dd);
    logic [12:0] hist[$];
    logic [12:0] s;
    twos_m = tw;
    ddr_m = dd;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      s = 13'($random(seed));
      hist.push_back(s);
      if (i >= 7) q.push_back(hist[i - 7] ^ {1'b0, tw, 11'h000});
      conv_valid = 1'b1;
      conv_or = s[12];
      conv_data = s[11:0];
      @(negedge ref_clk);
      conv_valid = 1'b0;
      if (i == 8) chk(stby, 1'b0);
      repeat (2) @(negedge ref_clk);
    end
    repeat (16) @(negedge ref_clk);
    chk(stby, 1'b1);
    chk(q.size(), 0);
  endtask

  task automatic wr(input logic [1:0] len, input logic [7:0] a,
      input logic [31:0] d);
    host_u.frame(1'b0, len, a, d, lsb_m, 1'b1, rd);
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic rd_chk(input logic [1:0] len, input logic [7:0] a,
      input logic [31:0] e);
    host_u.frame(1'b1, len, a, 32'h0, lsb_m, 1'b1, rd);
    chk(rd, e);
    @(negedge ref_clk);
    chk(d_oe, 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hdad89a5a;
    num_errors = 0;
    n_tests = 0;
    srst = 1'b1;
    mrst_n = 1'b0;
    conv_valid = 1'b0;
    conv_or = 1'b0;
    conv_data = 12'h000;
    ddr_m = 1'b0;
    twos_m = 1'b0;
    lsb_m = 1'b0;
    for (int k = 0; k < 2; k++) begin
      reset_dut(1'b0, k[0], ~k[0]);
      stream(10, ~k[0], 1'b0);
      chk({duty_cycle_stabilizer, reduced}, {k[0], 1'b0});
      $display("Strap test %0d done", k);
    end
    reset_dut(1'b1, 1'b0, 1'b0);
    chk({duty_cycle_stabilizer, reduced}, 2'b10);
    foreach (ra[i]) rd_chk(2'b00, ra[i], {rv[i], 24'h0});
    stream(12, 1'b0, 1'b0);
    $display("Defaults and offset binary done");
    wr(2'b00, 8'h14, 32'h01000000);
    stream(12, 1'b1, 1'b0);
    wr(2'b01, 8'h14, 32'h09010000);
    chk(reduced, 1'b1);
    stream(12, 1'b1, 1'b1);
    rd_chk(2'b01, 8'h14, 32'h09010000);
    $display("Coding and rate modes done");
    wr(2'b00, 8'h01, 32'hFF000000);
    rd_chk(2'b00, 8'h01, 32'h5A000000);
    host_u.frame(1'b0, 2'b00, 8'h09, 32'h0, 1'b0, 1'b0, rd);
    repeat (8) @(negedge ref_clk);
    rd_chk(2'b00, 8'h09, 32'h01000000);
    chk(duty_cycle_stabilizer, 1'b1);
    wr(2'b00, 8'h00, 32'h5A000000);
    lsb_m = 1'b1;
    rd_chk(2'b00, 8'h14, 32'h09000000);
    rd_chk(2'b00, 8'h00, 32'h5A000000);
    $display("Serial port tests done");
    @(negedge ref_clk);
    mrst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    mrst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    lsb_m = 1'b0;
    rd_chk(2'b00, 8'h00, 32'h18000000);
    rd_chk(2'b00, 8'h14, 32'h00000000);
    chk({duty_cycle_stabilizer, reduced}, 2'b10);
    stream(12, 1'b0, 1'b0);
    $display("Master reset test done");
    close_out();
  end
endmodule
